/* common/link_status_pkg.sv */
// Purpose: constants and types for the link status and error reply registers
// Assumes: 32-bit apb, one aligned word per register
// Notes:   one clock, asynchronous active-low reset
//
// Overview of operation
// - transceiver_lock_status bits 15:0 show per-channel recovered clock lock
// - half width: lock bits 15:8 read zero
// - lane status 31:16 word boundary found; half width top eight zero
// - lane status 15:0 show descrambler synced; half width upper eight zero
// - link status bit 16 mirrors peer power-state input level
// - link status bit 8 set when all lanes deskewed
// - six-bit one-hot init state in bits 5:0, resets to reset state
// - each error response packet pushes code and cube id into fifo, dropped when fifo full
// - reading error reply register returns head entry then pops it
// - read/write/mode responses with error bypass queue, flagged on datapath
// - bit 16 valid only when queue holds an entry
// - cube identifier in bits 10:8
// - seven-bit error code in bits 6:0
// - interrupt source raised while queue non-empty
package link_status_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] XCVR_LOCK_OFF  = 8'h08;
    localparam logic [7:0] LANE_SYNC_OFF  = 8'h0c;
    localparam logic [7:0] LINK_STATE_OFF = 8'h10;
    localparam logic [7:0] ERR_REPLY_OFF  = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFF   = 8'h1c;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int WORD_LOCK_LSB   = 16;
    localparam int PEER_PS_BIT     = 16;
    localparam int DESKEW_BIT      = 8;
    localparam int ERR_VALID_BIT   = 16;
    localparam int CUBE_LSB        = 8;
    localparam int IRQ_ERR_BIT     = 0;
    localparam int IRQ_WIDTH       = 1;

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [5:0] INIT_ACTIVE   = 6'h20;
    localparam logic [5:0] INIT_TRET     = 6'h10;
    localparam logic [5:0] INIT_TS1      = 6'h08;
    localparam logic [5:0] INIT_NULLS    = 6'h04;
    localparam logic [5:0] INIT_I2C_CFG  = 6'h02;
    localparam logic [5:0] INIT_RESET    = 6'h01;
    localparam logic [31:0] LINK_STATE_RST = 32'h0000_0001;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

    typedef enum logic [1:0] {
        RSP_READ,
        RSP_WRITE,
        RSP_MODE,
        RSP_ERROR
    } rsp_kind_t;

    // one received response as seen by this block
    typedef struct packed {
        logic       valid;
        rsp_kind_t  kind;
        logic [2:0] cube;
        logic [6:0] errstat;
    } rx_rsp_t;

    typedef struct packed {
        logic [2:0] cube;
        logic [6:0] errstat;
    } err_entry_t;

endpackage : link_status_pkg

/* core/err_reply_fifo.sv */
// Purpose: small fifo of error reply entries
// Assumes: pop only when not empty
// Notes:   push on full is dropped; simultaneous push and pop allowed
`timescale 1ns/1ps
module err_reply_fifo
    import link_status_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       push,
    input  wire err_entry_t push_data,
    input  wire logic       pop,
    output err_entry_t      head,
    output logic            not_empty,
    output logic            full
);
    err_entry_t       mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              do_push = push && !full;
    wire              do_pop  = pop && not_empty;

    assign not_empty = (cnt_q != '0);
    assign full      = (cnt_q == (AW+1)'(DEPTH));
    assign head      = mem[rd_q];

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    empty_pop_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (pop && !not_empty && !push) |=> !not_empty)
        else $error("pop while empty changed the fifo");
endmodule : err_reply_fifo

/* core/rsp_classifier.sv */
// Purpose: split received responses into error queue pushes and datapath flag
// Assumes: one response per cycle at most
// Notes:   outputs are registered one cycle after the input
`timescale 1ns/1ps
module rsp_classifier
    import link_status_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    input  wire rx_rsp_t rsp_in,
    output logic         push,
    output err_entry_t   push_data,
    output logic         datapath_response_error_flag
);
    wire is_err_pkt = rsp_in.valid && (rsp_in.kind == RSP_ERROR);
    wire is_bad_rsp = rsp_in.valid && (rsp_in.kind != RSP_ERROR)
                      && (rsp_in.errstat != 7'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push                         <= 1'b0;
            push_data                    <= '0;
            datapath_response_error_flag <= 1'b0;
        end else begin
            push                         <= is_err_pkt;
            push_data                    <= '{rsp_in.cube, rsp_in.errstat};
            datapath_response_error_flag <= is_bad_rsp;
        end
    end

    bad_rsp_bypass_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        is_bad_rsp |=> (datapath_response_error_flag && !push))
        else $error("errored response entered queue or lost flag");
endmodule : rsp_classifier

/* core/link_status_regs.sv */
// Purpose: apb status registers for link lock, sync, init state, error replies
// Assumes: status inputs synchronous to pclk
// Notes:   apb answers with zero wait states, pslverr on unmapped address
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module link_status_regs
    import link_status_pkg::*;
#(
    parameter int  LANES      = 16,
    parameter bit  HALF_WIDTH = 1'b0,
    parameter int  FIFO_DEPTH = 8,
    parameter int  FIFO_AW    = 3
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [LANES-1:0]  recovered_clock_locked,
    input  wire logic [LANES-1:0]  lane_word_boundary_found,
    input  wire logic [LANES-1:0]  lane_descrambler_synced,
    input  wire logic              peer_power_state_level,
    input  wire logic              all_lanes_deskewed,
    input  wire logic [5:0]        link_init_state,
    input  wire rx_rsp_t           rx_rsp,
    output logic                   datapath_response_error_flag,
    output logic                   irq
);
    // ----------------------------------------
    // lane masking
    // ----------------------------------------
    function automatic logic [15:0] lane_mask(input logic [LANES-1:0] v);
        logic [15:0] w;
        w = 16'(v);
        if (HALF_WIDTH) begin
            w[15:8] = 8'h00;
        end
        return w;
    endfunction : lane_mask

    wire [15:0] cdr_bits  = lane_mask(recovered_clock_locked);
    wire [15:0] word_bits = lane_mask(lane_word_boundary_found);
    wire [15:0] desc_bits = lane_mask(lane_descrambler_synced);

    // ----------------------------------------
    // status input capture
    // ----------------------------------------
    logic [5:0] init_q;
    logic [15:0] cdr_q;
    logic [15:0] word_q;
    logic [15:0] desc_q;
    logic        ps_q;
    logic        deskew_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q   <= LINK_STATE_RST[5:0];
            cdr_q    <= '0;
            word_q   <= '0;
            desc_q   <= '0;
            ps_q     <= 1'b0;
            deskew_q <= 1'b0;
        end else begin
            init_q   <= link_init_state;
            cdr_q    <= cdr_bits;
            word_q   <= word_bits;
            desc_q   <= desc_bits;
            ps_q     <= peer_power_state_level;
            deskew_q <= all_lanes_deskewed;
        end
    end

    // ----------------------------------------
    // error reply queue
    // ----------------------------------------
    logic       q_push;
    err_entry_t q_push_data;
    err_entry_t q_head;
    logic       q_not_empty;
    logic       q_full;
    logic       dp_err_flag;

    rsp_classifier u_cls (
        .pclk                         (pclk),
        .presetn                      (presetn),
        .rsp_in                       (rx_rsp),
        .push                         (q_push),
        .push_data                    (q_push_data),
        .datapath_response_error_flag (dp_err_flag)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire setup_phase = psel && !penable;
    wire access_rd   = psel && penable && !pwrite;
    wire access_wr   = psel && penable && pwrite;
    wire hit_xcvr    = (paddr == XCVR_LOCK_OFF);
    wire hit_lane    = (paddr == LANE_SYNC_OFF);
    wire hit_link    = (paddr == LINK_STATE_OFF);
    wire hit_err     = (paddr == ERR_REPLY_OFF);
    wire hit_istat   = (paddr == IRQ_STATUS_OFF);
    wire hit_imask   = (paddr == IRQ_MASK_OFF);
    wire hit_any     = hit_xcvr | hit_lane | hit_link | hit_err
                       | hit_istat | hit_imask;
    // read-only regs refuse writes except the mask
    wire bad_access  = !hit_any || (pwrite && !hit_imask);

    // pop only what the setup cycle showed as valid; an entry
    // landing between setup and access must wait for the next read
    logic pop_ok_q;
    wire  q_pop      = access_rd && hit_err && pop_ok_q;

    err_reply_fifo #(
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (q_push),
        .push_data (q_push_data),
        .pop       (q_pop),
        .head      (q_head),
        .not_empty (q_not_empty),
        .full      (q_full)
    );

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [IRQ_WIDTH-1:0] istat_q;
    logic [IRQ_WIDTH-1:0] imask_q;
    logic                 nempty_q;
    wire  err_event = q_not_empty && !nempty_q;
    wire  istat_rd  = access_rd && hit_istat;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q  <= '0;
            imask_q  <= '0;
            nempty_q <= 1'b0;
        end else begin
            nempty_q <= q_not_empty;
            // set wins over read clear
            if (err_event) begin
                istat_q[IRQ_ERR_BIT] <= 1'b1;
            end else if (istat_rd) begin
                istat_q[IRQ_ERR_BIT] <= 1'b0;
            end
            if (access_wr && hit_imask) begin
                imask_q <= pwdata[IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = ZERO_WORD;
        if (hit_xcvr) begin
            rd_word[15:0] = cdr_q;
        end
        if (hit_lane) begin
            rd_word[WORD_LOCK_LSB +: 16] = word_q;
            rd_word[15:0]                = desc_q;
        end
        if (hit_link) begin
            rd_word[PEER_PS_BIT] = ps_q;
            rd_word[DESKEW_BIT]  = deskew_q;
            rd_word[5:0]         = init_q;
        end
        if (hit_err) begin
            rd_word[ERR_VALID_BIT] = q_not_empty;
            if (q_not_empty) begin
                rd_word[CUBE_LSB +: 3] = q_head.cube;
                rd_word[6:0]           = q_head.errstat;
            end
        end
        if (hit_istat) begin
            rd_word[IRQ_WIDTH-1:0] = istat_q;
        end
        if (hit_imask) begin
            rd_word[IRQ_WIDTH-1:0] = imask_q;
        end
    end

    // ----------------------------------------
    // apb answer registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            pop_ok_q <= 1'b0;
        end else begin
            // answer registered in setup so access sees it at once
            pready  <= setup_phase;
            pslverr <= setup_phase && bad_access;
            prdata  <= (setup_phase && !pwrite) ? rd_word : ZERO_WORD;
            pop_ok_q <= setup_phase && !pwrite && hit_err && q_not_empty;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq                          <= 1'b0;
            datapath_response_error_flag <= 1'b0;
        end else begin
            irq <= |(istat_q & imask_q) || (q_not_empty && imask_q[0]);
            datapath_response_error_flag <= dp_err_flag;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // reset state
    init_reset_a: assert property (@(posedge pclk)
        $rose(presetn) |-> init_q == INIT_RESET)
        else $error("init state not reset state after reset");

    read_pops_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q_pop && q_not_empty && !q_push && !u_fifo.full)
        |=> u_fifo.cnt_q == $past(u_fifo.cnt_q) - 1'b1)
        else $error("read of error reply did not pop");

    push_grows_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q_push && !q_pop && !q_full)
        |=> u_fifo.cnt_q == $past(u_fifo.cnt_q) + 1'b1)
        else $error("error packet not queued");

    valid_bit_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_err && !pwrite)
        |=> prdata[ERR_VALID_BIT] == $past(q_not_empty))
        else $error("valid bit disagrees with queue");

    half_width_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        HALF_WIDTH |-> (cdr_q[15:8] == 8'h00 && word_q[15:8] == 8'h00
                        && desc_q[15:8] == 8'h00))
        else $error("half width upper lanes not zero");

    peer_level_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 ps_q == $past(peer_power_state_level))
        else $error("peer level not mirrored");

    deskew_flag_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        all_lanes_deskewed |=> deskew_q)
        else $error("deskew flag missed");

    irq_pending_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q_not_empty && imask_q[0]) |=> irq)
        else $error("interrupt not raised for pending entry");

    lock_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_xcvr && !pwrite)
        |=> prdata == {16'h0000, $past(cdr_q)})
        else $error("lock bits not returned");

    word_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_lane && !pwrite)
        |=> prdata[31:16] == $past(word_q))
        else $error("word boundary bits not returned");

    desc_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_lane && !pwrite)
        |=> prdata[15:0] == $past(desc_q))
        else $error("descrambler bits not returned");

    link_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_link && !pwrite)
        |=> prdata == {15'h0000, $past(ps_q), 7'h00, $past(deskew_q),
                       2'b00, $past(init_q)})
        else $error("link state word wrong");

    cube_field_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_err && !pwrite && q_not_empty)
        |=> prdata[10:8] == $past(q_head.cube))
        else $error("cube identifier field wrong");

    errstat_field_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_err && !pwrite && q_not_empty)
        |=> prdata[6:0] == $past(q_head.errstat))
        else $error("error code field wrong");

    empty_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (setup_phase && hit_err && !pwrite && !q_not_empty)
        |=> (prdata == ZERO_WORD && !q_pop))
        else $error("empty read returned data or popped");

    head_kept_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q_not_empty && !q_pop) |=> q_head == $past(q_head))
        else $error("queue head moved without a read");

    istat_set_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        err_event |=> istat_q[IRQ_ERR_BIT])
        else $error("interrupt status not set by new entry");

    dp_flag_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        dp_err_flag |=> datapath_response_error_flag)
        else $error("datapath error flag not forwarded");

endmodule : link_status_regs

/* verif/link_status_regs_tb.sv */
// Purpose: self-checking bench for the link status register bank
// Assumes: zero-wait apb slave, full and half width instances side by side
// Notes:   status rows in a table, error queue and interrupt by hand
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s expected %h seen %h", n, e, g); \
    end end
module link_status_regs_tb
    import link_status_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [15:0] lock    = 16'h0;
    logic [15:0] wlock   = 16'h0;
    logic [15:0] dsync   = 16'h0;
    logic        ps      = 1'b0;
    logic        dsk     = 1'b0;
    logic [5:0]  init    = 6'h01;
    rx_rsp_t     rx_rsp  = '0;
    logic [31:0] prdata, prdata_h, rd, rdh;
    logic        pready, pready_h, pslverr, pslverr_h, er;
    logic        flag, flag_h, irq, irq_h;
    int          err_count, total_checks, flag_count;
    typedef struct packed {
        logic [15:0] lk, wl, ds;
        logic        ps, dk;
        logic [5:0]  st;
        logic [7:0]  a;
        logic [31:0] ef, eh;
    } row_t;
    row_t rows [8];

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (flag === 1'b1 && flag_h === 1'b1) flag_count++;

    link_status_regs u_link_status_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .recovered_clock_locked(lock),
        .lane_word_boundary_found(wlock), .lane_descrambler_synced(dsync),
        .peer_power_state_level(ps), .all_lanes_deskewed(dsk),
        .link_init_state(init), .rx_rsp(rx_rsp),
        .datapath_response_error_flag(flag), .irq(irq));
    link_status_regs #(.HALF_WIDTH(1'b1)) u_link_status_regs_half (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_h),
        .pready(pready_h), .pslverr(pslverr_h),
        .recovered_clock_locked(lock), .lane_word_boundary_found(wlock),
        .lane_descrambler_synced(dsync), .peer_power_state_level(ps),
        .all_lanes_deskewed(dsk), .link_init_state(init), .rx_rsp(rx_rsp),
        .datapath_response_error_flag(flag_h), .irq(irq_h));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
        rd  = prdata;
        rdh = prdata_h;
        er  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic send(input rsp_kind_t k, input logic [2:0] c,
                        input logic [6:0] e);
        @(posedge pclk);
        rx_rsp <= '{valid: 1'b1, kind: k, cube: c, errstat: e};
    endtask : send

    task automatic idle(input int n);
        @(posedge pclk);
        rx_rsp.valid <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic pop_chk(input logic [31:0] e);
        apb(1'b0, ERR_REPLY_OFF, 32'h0);
        `CHK("err_reply", e, rd)
    endtask : pop_chk

    initial begin
        #(25ns * 20000);
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{16'ha5c3, 16'h0, 16'h0, 1'b0, 1'b0, 6'h01, 8'h08,
                    32'h0000a5c3, 32'h000000c3};
        rows[1] = '{16'h0, 16'h8001, 16'hff10, 1'b0, 1'b0, 6'h01, 8'h0c,
                    32'h8001ff10, 32'h00010010};
        rows[2] = '{16'h0, 16'h0, 16'h0, 1'b1, 1'b1, 6'h20, 8'h10,
                    32'h00010120, 32'h00010120};
        rows[3] = '{16'h0, 16'h0, 16'h0, 1'b0, 1'b1, 6'h10, 8'h10,
                    32'h00000110, 32'h00000110};
        rows[4] = '{16'h0, 16'h0, 16'h0, 1'b1, 1'b0, 6'h08, 8'h10,
                    32'h00010008, 32'h00010008};
        rows[5] = '{16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 6'h04, 8'h10,
                    32'h00000004, 32'h00000004};
        rows[6] = '{16'h0, 16'h0, 16'h0, 1'b1, 1'b1, 6'h02, 8'h10,
                    32'h00010102, 32'h00010102};
        rows[7] = '{16'hffff, 16'h0, 16'h0, 1'b0, 1'b0, 6'h01, 8'h08,
                    32'h0000ffff, 32'h000000ff};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LINK_STATE_OFF, 32'h0);
        `CHK("link_rst", LINK_STATE_RST, rd)
        pop_chk(ZERO_WORD);
        // table of status inputs against both widths
        foreach (rows[i]) begin
            @(posedge pclk);
            lock  <= rows[i].lk;
            wlock <= rows[i].wl;
            dsync <= rows[i].ds;
            ps    <= rows[i].ps;
            dsk   <= rows[i].dk;
            init  <= rows[i].st;
            repeat (2) @(posedge pclk);
            apb(1'b0, rows[i].a, 32'h0);
            `CHK("status_full", rows[i].ef, rd)
            `CHK("status_half", rows[i].eh, rdh)
        end
        // errors queued, other kinds with nonzero status flagged on the datapath
        apb(1'b1, IRQ_MASK_OFF, 32'h1);
        `CHK("mask_wr_err", 1'b0, er)
        send(RSP_ERROR, 3'h5, 7'h41);
        send(RSP_READ, 3'h1, 7'h22);
        send(RSP_ERROR, 3'h2, 7'h7f);
        send(RSP_WRITE, 3'h3, 7'h01);
        send(RSP_MODE, 3'h4, 7'h10);
        send(RSP_READ, 3'h6, 7'h00);
        send(RSP_ERROR, 3'h7, 7'h00);
        idle(4);
        `CHK("dp_flags", 3, flag_count)
        `CHK("irq_pending", 1'b1, irq)
        `CHK("irq_pending_h", 1'b1, irq_h)
        pop_chk(32'h00010541);
        pop_chk(32'h0001027f);
        pop_chk(32'h00010700);
        pop_chk(ZERO_WORD);
        pop_chk(ZERO_WORD);
        apb(1'b0, IRQ_STATUS_OFF, 32'h0);
        `CHK("istat_set", 32'h1, rd)
        apb(1'b0, IRQ_STATUS_OFF, 32'h0);
        `CHK("istat_clr", 32'h0, rd)
        repeat (2) @(posedge pclk);
        `CHK("irq_idle", 1'b0, irq)
        `CHK("irq_idle_h", 1'b0, irq_h)
        // masked event stays sticky, unmask raises the line
        apb(1'b1, IRQ_MASK_OFF, 32'h0);
        send(RSP_ERROR, 3'h1, 7'h33);
        idle(4);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, IRQ_MASK_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq_unmask", 1'b1, irq)
        pop_chk(32'h00010133);
        // overfill: ninth entry dropped, writes and an unmapped read refused without a pop
        for (int i = 0; i < 9; i++) begin
            send(RSP_ERROR, i[2:0], 7'h10 + i[6:0]);
        end
        idle(3);
        apb(1'b1, ERR_REPLY_OFF, 32'hffff_ffff);
        `CHK("ro_write_err", 1'b1, er)
        apb(1'b1, XCVR_LOCK_OFF, 32'hffff_ffff);
        `CHK("ro_lock_err", 1'b1, er)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        for (int i = 0; i < 8; i++) begin
            pop_chk({15'h0, 1'b1, 5'h0, i[2:0], 1'b0, 7'h10 + i[6:0]});
        end
        pop_chk(ZERO_WORD);
        // reset in mid-run empties the queue
        send(RSP_ERROR, 3'h2, 7'h05);
        send(RSP_ERROR, 3'h3, 7'h06);
        idle(3);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        pop_chk(ZERO_WORD);
        `CHK("irq_after_rst", 1'b0, irq)
        `CHK("irq_after_rst_h", 1'b0, irq_h)
        tally_and_finish();
    end
endmodule : link_status_regs_tb
